//--- crc_pkg.sv
// Purpose: constants, types and helpers for the clock ratio host controller.
// Assumes: device word bus with byte/word sizes; one 10 MHz clock.
// Notes: device addresses are byte addresses on the device's own bus.
// Function
// - ratio register takes word accesses only
// - multiplier code bits 15,5,4; five legal codes
// - core divider code bits 14,3,2; four codes
// - peripheral divider code bits 13,1,0; five codes
// - bits 12-9,7,6 read and written zero
// - bit 8 reads and is written one
// - core clock never below bus clock
// - peripheral clock never above bus clock
// - stop, configure, load watchdog before multiplier change
// - only dividers legal for mode and multiplier
// - no core divider change during busy DMA; refused only when the multiplier is unchanged and I:B is not 1:1
// - watchdog writes are words with key upper byte
// - watchdog reads are bytes; byte/long writes fail

package crc_pkg;

    // ----------------------------------------------------------------
    // device map
    // ----------------------------------------------------------------
    localparam logic [31:0] CRC_WD_CNT_ADDR = 32'hFFFF_FF84;
    localparam logic [31:0] CRC_WD_CSR_ADDR = 32'hFFFF_FF86;
    localparam logic [31:0] CRC_FRQ_ADDR = 32'hFFFF_FF80;
    localparam logic [15:0] CRC_FRQ_RESET = 16'h0102;
    localparam logic [15:0] CRC_FRQ_ONES = 16'h0100;
    localparam logic [7:0] CRC_KEY_CNT = 8'h5A;
    localparam logic [7:0] CRC_KEY_CSR = 8'hA5;
    localparam logic [7:0] CRC_CSR_STOPPED = 8'h00;
    localparam int CRC_CSR_RUN_BIT = 7;
    localparam int CRC_MULT_HI = 15;
    localparam int CRC_MULT_MID = 5;
    localparam int CRC_MULT_LO = 4;
    localparam int CRC_CORE_HI = 14;
    localparam int CRC_CORE_MID = 3;
    localparam int CRC_CORE_LO = 2;
    localparam int CRC_PERI_HI = 13;
    localparam int CRC_PERI_MID = 1;
    localparam int CRC_PERI_LO = 0;
    localparam logic [2:0] CRC_CODE_X6 = 3'h5;

    // ----------------------------------------------------------------
    // own register map
    // ----------------------------------------------------------------
    localparam logic [7:0] CRC_OFS_TARGET = 8'h00;
    localparam logic [7:0] CRC_OFS_CMD = 8'h04;
    localparam logic [7:0] CRC_OFS_STATUS = 8'h08;
    localparam logic [7:0] CRC_OFS_DATA = 8'h0C;
    localparam int CRC_T_MULT = 0;
    localparam int CRC_T_CORE = 4;
    localparam int CRC_T_PERI = 8;
    localparam int CRC_T_CKS = 12;
    localparam int CRC_T_INIT = 16;
    localparam logic [31:0] CRC_TARGET_RESET = 32'h0000_0200;
    localparam int CRC_CMD_GO = 0;
    localparam int CRC_CMD_RD_CNT = 1;
    localparam int CRC_CMD_RD_CSR = 2;
    localparam int CRC_CMD_RD_FRQ = 3;

    typedef enum logic [1:0] {CRC_SZ_BYTE, CRC_SZ_WORD, CRC_SZ_LONG} crc_size_type;

    typedef struct packed {
        logic req;
        logic we;
        crc_size_type size;
        logic [31:0] addr;
        logic [15:0] wdata;
    } crc_dev_req_type;

    // code to ratio figure; zero marks an illegal code
    function automatic logic [2:0] crc_ratio(input logic [2:0] code);
        case (code)
            3'h0: crc_ratio = 3'h1;
            3'h1: crc_ratio = 3'h2;
            3'h4: crc_ratio = 3'h3;
            3'h2: crc_ratio = 3'h4;
            3'h5: crc_ratio = 3'h6;
            default: crc_ratio = 3'h0;
        endcase
    endfunction : crc_ratio

    function automatic logic [2:0] crc_pick(input logic [15:0] w, input int hi,
                                            input int mid, input int lo);
        crc_pick = {w[hi], w[mid], w[lo]};
    endfunction : crc_pick

    function automatic logic [15:0] crc_frq_word(input logic [2:0] m, input logic [2:0] c,
                                                 input logic [2:0] p);
        logic [15:0] w;
        w = CRC_FRQ_ONES;
        {w[CRC_MULT_HI], w[CRC_MULT_MID], w[CRC_MULT_LO]} = m;
        {w[CRC_CORE_HI], w[CRC_CORE_MID], w[CRC_CORE_LO]} = c;
        {w[CRC_PERI_HI], w[CRC_PERI_MID], w[CRC_PERI_LO]} = p;
        crc_frq_word = w;
    endfunction : crc_frq_word

    function automatic logic [31:0] crc_lane_mask(input logic [3:0] sel);
        crc_lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : crc_lane_mask

endpackage : crc_pkg

//--- crc_ratio_host.sv
// Purpose: host controller that retunes the clock ratio register of the device.
// Assumes: device bus holds req until ack; device reset together with rst_i.
// Notes: software drives it over a classic Wishbone slave.
`timescale 1ns/100ps
`default_nettype none

module crc_ratio_host (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // device bus
    output crc_pkg::crc_dev_req_type dev_req_o,
    input wire logic dev_ack_i,
    input wire logic [15:0] dev_rdata_i,
    input wire logic dma_busy_i,
    // status
    output logic busy_o
);
    import crc_pkg::*;

    typedef enum {ST_IDLE, ST_CSR, ST_CNT, ST_FRQ, ST_READ} crc_state_type;

    crc_state_type state;
    crc_state_type next_state;
    logic [31:0] target;
    logic [15:0] shadow;
    logic [15:0] rdata;
    logic [2:0] err;
    logic settle;
    logic [31:0] rd_addr;
    logic rd_byte;
    crc_dev_req_type acc;

    // ----------------------------------------------------------------
    // wishbone decode
    // ----------------------------------------------------------------
    wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_hit & wb_we_i;
    wire idle = (state == ST_IDLE);
    wire hit_target = (wb_adr_i == CRC_OFS_TARGET);
    wire hit_cmd = (wb_adr_i == CRC_OFS_CMD);
    wire hit_status = (wb_adr_i == CRC_OFS_STATUS);
    wire hit_data = (wb_adr_i == CRC_OFS_DATA);
    wire [31:0] lane_mask = crc_lane_mask(wb_sel_i);
    wire [31:0] next_target = (target & ~lane_mask) | (wb_dat_i & lane_mask);
    wire cmd_wr = wb_wr & hit_cmd & wb_sel_i[0] & idle;
    wire go = cmd_wr & wb_dat_i[CRC_CMD_GO];
    wire rd_cnt = cmd_wr & wb_dat_i[CRC_CMD_RD_CNT];
    wire rd_csr = cmd_wr & wb_dat_i[CRC_CMD_RD_CSR];
    wire rd_frq = cmd_wr & wb_dat_i[CRC_CMD_RD_FRQ];
    wire rd_any = rd_cnt | rd_csr | rd_frq;

    // ----------------------------------------------------------------
    // ratio checks
    // ----------------------------------------------------------------
    wire [2:0] t_mult = target[CRC_T_MULT +: 3];
    wire [2:0] t_core = target[CRC_T_CORE +: 3];
    wire [2:0] t_peri = target[CRC_T_PERI +: 3];
    wire [2:0] t_cks = target[CRC_T_CKS +: 3];
    wire [7:0] t_init = target[CRC_T_INIT +: 8];
    wire [2:0] m_f = crc_ratio(t_mult);
    wire [2:0] c_f = crc_ratio(t_core);
    wire [2:0] p_f = crc_ratio(t_peri);
    wire [2:0] cur_mult = crc_pick(shadow, CRC_MULT_HI, CRC_MULT_MID, CRC_MULT_LO);
    wire [2:0] cur_core = crc_pick(shadow, CRC_CORE_HI, CRC_CORE_MID, CRC_CORE_LO);
    // illegal codes refused before reaching the device
    wire code_bad = (m_f == 3'h0) | (c_f == 3'h0) | (t_core == CRC_CODE_X6) | (p_f == 3'h0);
    // core not below bus, peripheral not above bus
    wire freq_bad = (m_f < c_f) | (m_f > p_f);
    wire mult_chg = (t_mult != cur_mult);
    wire core_chg = (t_core != cur_core);
    // core divider change under DMA with I:B not 1:1
    wire dma_bad = dma_busy_i & core_chg & ~mult_chg & (m_f != c_f);
    wire go_ok = go & ~code_bad & ~freq_bad & ~dma_bad;
    wire [15:0] new_frq = crc_frq_word(t_mult, t_core, t_peri);
    wire dev_done = dev_req_o.req & dev_ack_i;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (go_ok)
                    next_state = mult_chg ? ST_CSR : ST_FRQ;
                else if (rd_any)
                    next_state = ST_READ;
            end
            ST_CSR:
                if (dev_done) next_state = ST_CNT;
            ST_CNT:
                if (dev_done) next_state = ST_FRQ;
            ST_FRQ:
                if (dev_done) next_state = ST_IDLE;
            ST_READ:
                if (dev_done) next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // access for the current step
    always_comb
    begin
        acc = '0;
        acc.req = 1'b1;
        acc.size = CRC_SZ_WORD;
        case (state)
            ST_CSR:
            begin
                // stop the counter and pick its clock first
                acc.we = 1'b1;
                acc.addr = CRC_WD_CSR_ADDR;
                acc.wdata = {CRC_KEY_CSR, CRC_CSR_STOPPED | {5'h00, t_cks}};
            end
            ST_CNT:
            begin
                acc.we = 1'b1;
                acc.addr = CRC_WD_CNT_ADDR;
                acc.wdata = {CRC_KEY_CNT, t_init};
            end
            ST_FRQ:
            begin
                // word write, reserved bits fixed
                acc.we = 1'b1;
                acc.addr = CRC_FRQ_ADDR;
                acc.wdata = new_frq;
            end
            ST_READ:
            begin
                acc.addr = rd_addr;
                acc.size = rd_byte ? CRC_SZ_BYTE : CRC_SZ_WORD;
            end
            default:
                acc.req = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= ST_IDLE;
            busy_o <= 1'b0;
            dev_req_o <= '0;
        end
        else
        begin
            state <= next_state;
            busy_o <= (next_state != ST_IDLE);
            if (dev_done)
                dev_req_o.req <= 1'b0;
            else if (!dev_req_o.req && !idle)
                dev_req_o <= acc;
        end
    end

    // ----------------------------------------------------------------
    // host state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            target <= CRC_TARGET_RESET;
            shadow <= CRC_FRQ_RESET;
            rdata <= 16'h0000;
            err <= 3'h0;
            settle <= 1'b0;
            rd_addr <= CRC_FRQ_ADDR;
            rd_byte <= 1'b0;
        end
        else
        begin
            if (wb_wr && hit_target && idle)
                target <= next_target;
            if (go)
                err <= {dma_bad, freq_bad, code_bad};
            if (go_ok)
                settle <= mult_chg; // device halts and counts
            if (idle && rd_any && !go_ok)
            begin
                rd_addr <= rd_frq ? CRC_FRQ_ADDR : (rd_csr ? CRC_WD_CSR_ADDR : CRC_WD_CNT_ADDR);
                rd_byte <= ~rd_frq;
            end
            if (dev_done && state == ST_FRQ)
                shadow <= new_frq; // tracks the device ratio register; rst_i loads CRC_FRQ_RESET
            if (dev_done && state == ST_READ)
                rdata <= rd_byte ? {8'h00, dev_rdata_i[7:0]} : dev_rdata_i;
        end
    end

    // ----------------------------------------------------------------
    // wishbone answer
    // ----------------------------------------------------------------
    wire [31:0] status_word = {27'h000_0000, settle, err, ~idle};
    wire [31:0] rd_word = hit_target ? target :
                          hit_status ? status_word :
                          hit_data ? {shadow, rdata} : 32'h0000_0000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= (wb_hit && !wb_we_i) ? rd_word : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking crc_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    wire frq_wr = dev_req_o.req & dev_req_o.we & (dev_req_o.addr == CRC_FRQ_ADDR);
    wire [2:0] o_mult = crc_pick(dev_req_o.wdata, CRC_MULT_HI, CRC_MULT_MID, CRC_MULT_LO);
    wire [2:0] o_core = crc_pick(dev_req_o.wdata, CRC_CORE_HI, CRC_CORE_MID, CRC_CORE_LO);
    wire [2:0] o_peri = crc_pick(dev_req_o.wdata, CRC_PERI_HI, CRC_PERI_MID, CRC_PERI_LO);

    chk_req_held_stable: assert property (
        dev_req_o.req && !dev_ack_i |=> dev_req_o.req && $stable(dev_req_o))
        else $error("device request changed before ack");
    chk_cnt_write_key: assert property (
        dev_req_o.req && dev_req_o.we && dev_req_o.addr == CRC_WD_CNT_ADDR
        |-> dev_req_o.wdata[15:8] == CRC_KEY_CNT && dev_req_o.size == CRC_SZ_WORD)
        else $error("count write lacks key or word size");
    chk_csr_stop_key: assert property (
        dev_req_o.req && dev_req_o.we && dev_req_o.addr == CRC_WD_CSR_ADDR
        |-> dev_req_o.wdata[15:8] == CRC_KEY_CSR && !dev_req_o.wdata[CRC_CSR_RUN_BIT])
        else $error("control write lacks key or leaves counter running");
    chk_wd_read_byte: assert property (
        dev_req_o.req && !dev_req_o.we && dev_req_o.addr != CRC_FRQ_ADDR
        |-> dev_req_o.size == CRC_SZ_BYTE)
        else $error("watchdog read not byte sized");
    chk_frq_word_fixed: assert property (
        frq_wr |-> dev_req_o.size == CRC_SZ_WORD
                   && (dev_req_o.wdata & 16'h1FC0) == CRC_FRQ_ONES)
        else $error("ratio write has bad size or reserved bits");
    chk_frq_codes_legal: assert property (
        frq_wr |-> crc_ratio(o_mult) != 3'h0 && crc_ratio(o_peri) != 3'h0
                   && crc_ratio(o_core) != 3'h0 && o_core != CRC_CODE_X6)
        else $error("ratio write carries reserved code");
    chk_frq_freq_bounds: assert property (
        frq_wr |-> crc_ratio(o_mult) >= crc_ratio(o_core)
                   && crc_ratio(o_mult) <= crc_ratio(o_peri))
        else $error("ratio write breaks bus clock bounds");
    chk_mult_needs_setup: assert property (
        $rose(dev_req_o.req) && frq_wr && o_mult != cur_mult
        |-> $past(state, 3) == ST_CNT || $past(state, 2) == ST_CNT)
        else $error("multiplier written without watchdog setup");
    chk_wb_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("wishbone ack held two cycles");
    chk_dat_zero_idle: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("wishbone data not zero outside ack");

    // ordering and access sizes of the device bus sequence
    chk_go_refused_quiet: assert property (
        go && !go_ok |=> !dev_req_o.req ##1 !dev_req_o.req)
        else $error("refused go reached the device");
    chk_mult_setup_path: assert property (
        go_ok && mult_chg |=> state == ST_CSR)
        else $error("multiplier change skipped watchdog setup");
    chk_cnt_after_csr: assert property (
        $rose(dev_req_o.req) && dev_req_o.we && dev_req_o.addr == CRC_WD_CNT_ADDR
        |-> $past(state, 2) == ST_CSR)
        else $error("count write not preceded by control write");
    chk_frq_read_word: assert property (
        dev_req_o.req && !dev_req_o.we && dev_req_o.addr == CRC_FRQ_ADDR
        |-> dev_req_o.size == CRC_SZ_WORD)
        else $error("ratio read not word sized");
    chk_req_gap: assert property (
        dev_done |=> !dev_req_o.req)
        else $error("device request not dropped after ack");

endmodule : crc_ratio_host

`default_nettype wire

//--- crc_dev_model.sv
// Purpose: behavioural model of the device's ratio and watchdog registers.
// Assumes: host holds a request until ack; device reset rides on rst_i.
// Notes: stalls its own bus while the clocks settle.
`timescale 1ns/100ps
`default_nettype none

module crc_dev_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // device bus
    input wire crc_pkg::crc_dev_req_type req_i,
    input wire logic slow_i,
    output logic ack_o,
    output logic [15:0] rdata_o,
    // settling state
    output logic settling_o
);
    import crc_pkg::*;

    logic [15:0] ratio;
    logic [7:0] cnt;
    logic [7:0] csr;
    logic [7:0] n_wr;
    logic [1:0] wait_cnt;
    logic [11:0] pre;
    logic [15:0] last;
    wire logic is_byte = req_i.size == CRC_SZ_BYTE;
    wire logic is_word = req_i.size == CRC_SZ_WORD;
    wire logic hit_cnt = req_i.addr == CRC_WD_CNT_ADDR;
    wire logic hit_csr = req_i.addr == CRC_WD_CSR_ADDR;
    wire logic hit_frq = req_i.addr == CRC_FRQ_ADDR;
    wire logic take = req_i.req && !ack_o && !settling_o && (!slow_i || wait_cnt == 2'h3);
    wire logic wr_ok = take && req_i.we && is_word;
    wire logic key_cnt = req_i.wdata[15:8] == CRC_KEY_CNT;
    wire logic key_csr = req_i.wdata[15:8] == CRC_KEY_CSR;
    wire logic [15:0] masked = (req_i.wdata & 16'hE03F) | CRC_FRQ_ONES;
    wire logic mult_new = {masked[15], masked[5:4]} != {ratio[15], ratio[5:4]};
    wire logic [31:0] shifts = 32'hCA86_5420;
    wire logic [3:0] sh = shifts[csr[2:0] * 4 +: 4];
    wire logic [11:0] div_top = (12'h001 << sh) - 12'h001;
    wire logic counting = settling_o || csr[CRC_CSR_RUN_BIT];
    wire logic tick = counting && pre == div_top;
    wire logic [15:0] rd = (is_byte && hit_cnt) ? {8'h00, cnt} :
                           (is_byte && hit_csr) ? {8'h00, csr} :
                           (is_word && hit_frq) ? ratio : 16'h0000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ratio <= CRC_FRQ_RESET;
            cnt <= 8'h00;
            csr <= 8'h00;
            n_wr <= 8'h00;
            wait_cnt <= 2'h0;
            pre <= 12'h000;
            last <= 16'h0000;
            ack_o <= 1'b0;
            rdata_o <= 16'h0000;
            settling_o <= 1'b0;
        end
        else
        begin
            ack_o <= take;
            wait_cnt <= (req_i.req && !ack_o && !take) ? wait_cnt + 2'h1 : 2'h0;
            // released bus shows the inverse of the last value
            rdata_o <= (take && !req_i.we) ? rd : ~last;
            if (take && !req_i.we)
                last <= rd;
            pre <= (tick || !counting) ? 12'h000 : pre + 12'h001;
            if (tick)
                cnt <= cnt + 8'h01;
            if (tick && cnt == 8'hFF && settling_o)
                settling_o <= 1'b0;
            if (wr_ok && hit_cnt && key_cnt)
                cnt <= req_i.wdata[7:0];
            if (wr_ok && hit_csr && key_csr)
                csr <= req_i.wdata[7:0];
            if (wr_ok && ((hit_cnt && key_cnt) || (hit_csr && key_csr) || hit_frq))
                n_wr <= n_wr + 8'h01;
            if (wr_ok && hit_frq)
            begin
                ratio <= masked;
                settling_o <= mult_new;
            end
        end
    end
endmodule : crc_dev_model

`default_nettype wire

//--- crc_tb.sv
// Purpose: self-checking bench for the clock ratio host controller.
// Assumes: device model answers on the device bus.
// Notes: a table of go commands drives most checks.
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import crc_pkg::*;

    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dma_busy_i, busy_o;
    logic slow, ack, settling;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [15:0] rdata, cur;
    crc_dev_req_type dev_req;
    int n_errors, n_tests;
    // mult, core, periph, dma, slow, expected status
    logic [15:0] plan [10] = '{16'h0080, 16'h4130, 16'h4558, 16'h4500, 16'h5004,
                               16'h4D02, 16'hA6B0, 16'h8210, 16'h2090, 16'h0110};

    crc_ratio_host DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .dev_req_o(dev_req), .dev_ack_i(ack),
        .dev_rdata_i(rdata), .dma_busy_i(dma_busy_i), .busy_o(busy_o));
    crc_dev_model MODEL (.clk_i(clk_i), .rst_i(rst_i), .req_i(dev_req), .slow_i(slow),
        .ack_o(ack), .rdata_o(rdata), .settling_o(settling));

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic wrap_up;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic hang(input string what);
        $display("Error at %0t: %s timed out", $time, what);
        n_errors++;
        wrap_up;
    endtask : hang

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask : check

    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        for (i = 0; i < 40 && wb_ack_o !== 1'b1; i++)
            @(posedge clk_i);
        q = wb_dat_o;
        if (i == 40)
            hang("bus");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb_xfer

    task automatic wait_idle;
        int i;
        for (i = 0; i < 50; i++)
        begin
            wb_xfer(1'b0, CRC_OFS_STATUS, 32'h0);
            if (q[0] === 1'b0)
                break;
        end
        if (i == 50)
            hang("busy");
        for (i = 0; i < 12000 && settling !== 1'b0; i++)
            @(posedge clk_i);
        if (i == 12000)
            hang("settle");
    endtask : wait_idle

    task automatic cmd(input logic [31:0] bits);
        wb_xfer(1'b1, CRC_OFS_CMD, bits);
        wait_idle;
        wb_xfer(1'b0, CRC_OFS_DATA, 32'h0);
    endtask : cmd

    task automatic run_entry(input int k);
        logic [15:0] e;
        logic [31:0] tgt;
        logic [7:0] nw0;
        logic [7:0] nw;
        logic ok;
        e = plan[k];
        tgt = {8'h00, 8'hFE, 1'b0, 3'(k), 1'b0, e[9:7], 1'b0, e[12:10], 1'b0, e[15:13]};
        ok = (e[3:1] == 3'h0);
        if (ok)
            cur = {e[15], e[12], e[9], 4'h0, 1'b1, 2'b00, e[14:13], e[11:10], e[8:7]};
        nw = !ok ? 8'h00 : (e[4] ? 8'h03 : 8'h01);
        nw0 = MODEL.n_wr;
        slow <= e[5];
        dma_busy_i <= e[6];
        wb_xfer(1'b1, CRC_OFS_TARGET, tgt);
        wb_xfer(1'b1, CRC_OFS_CMD, 32'h1);
        check({31'h0, busy_o}, {31'h0, ok});
        if (e[5])
            wb_xfer(1'b1, CRC_OFS_TARGET, 32'hFFFF_FFFF);
        wait_idle;
        wb_xfer(1'b0, CRC_OFS_STATUS, 32'h0);
        check(q, {27'h0, e[4:0]});
        check({16'h0, MODEL.ratio}, {16'h0, cur});
        check({24'h0, MODEL.n_wr - nw0}, {24'h0, nw});
        wb_xfer(1'b0, CRC_OFS_TARGET, 32'h0);
        check(q, tgt);
        if (e[4] && ok)
        begin
            cmd(32'h2);
            check(q, {cur, 16'h0000});
            cmd(32'h4);
            check(q, {cur, 13'h0, 3'(k)});
        end
        $display("test go %0d done", k);
    endtask : run_entry

    initial
    begin
        n_errors = 0;
        n_tests = 0;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, dma_busy_i, slow} = 5'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        cur = 16'h0102;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_xfer(1'b0, CRC_OFS_TARGET, 32'h0);
        check(q, 32'h0000_0200);
        wb_xfer(1'b0, CRC_OFS_STATUS, 32'h0);
        check(q, 32'h0000_0000);
        wb_xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
        wb_xfer(1'b0, 8'h40, 32'h0);
        check(q, 32'h0000_0000);
        cmd(32'h8);
        check(q, 32'h0102_0102);
        cmd(32'h2);
        check(q, 32'h0102_0000);
        cmd(32'h4);
        check(q, 32'h0102_0000);
        $display("test reset done");
        for (int k = 0; k < 10; k++)
            run_entry(k);
        wrap_up;
    end
endmodule : testbench

`default_nettype wire
